// ===== src/sdr_diag_report.sv
// diagnostic report latching, fault indicator and output gating
`timescale 1ns/1ps
`include "sdr_regs.svh"
module sdr_diag_report
   import sdr_pkg::*;
#(
   parameter bit HAS_SERIAL    = 1'b1,
   parameter bit HAS_CLEAR_PIN = 1'b0
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic [`SDR_NUM_CH-1:0]   openLoadCond,
   input  wire logic [`SDR_NUM_CH-1:0]   overCurrentCond,
   input  wire logic [`SDR_NUM_CH-1:0]   overTempCond,
   input  wire logic                     overTempAllCond,
   input  wire logic                     supplyBelowLowWarning,
   input  wire logic                     supplyBelowUndervoltage,
   input  wire logic                     supplyAboveOvervoltage,
   input  wire logic                     logicSupplyUndervoltage,
   input  wire logic                     commLinkLost,
   input  wire logic [`SDR_NUM_CH-1:0]   channelOnRequest,
   input  wire logic                     clearFaultPin_n,
   input  wire logic                     faultEnableWrite,
   input  wire logic [7:0]               faultEnableData,
   input  wire logic                     autoClearEnableWrite,
   input  wire logic [7:0]               autoClearEnableData,
   input  wire logic                     clearDiagnosticWrite,
   input  wire logic [7:0]               clearDiagnosticData,
   output logic [7:0]                    faultEnableMask,
   output logic [7:0]                    autoClearEnableMask,
   output logic [7:0]                    masterDiagnosticStatus,
   output logic [`SDR_NUM_CH-1:0]        openLoadReport,
   output logic [`SDR_NUM_CH-1:0]        overCurrentReport,
   output logic [`SDR_NUM_CH-1:0]        overTempReport,
   output logic                          faultIndicatorPinOut,
   output logic                          faultIndicatorPinOe,
   output logic                          supplyWarningPinOut,
   output logic                          supplyWarningPinOe,
   output logic [`SDR_NUM_CH-1:0]        channelEnable,
   output logic                          clampLowVoltage
);
   localparam int NCH = `SDR_NUM_CH;
   localparam int NIN = 3 * NCH + 6;

   // two-flop synchronisers on all asynchronous condition inputs
   logic [NIN-1:0] rawIn;
   logic [NIN-1:0] syncA_reg;
   logic [NIN-1:0] syncB_reg;
   logic [NIN-1:0] syncA_next;
   logic [NIN-1:0] syncB_next;
   assign rawIn = {openLoadCond, overCurrentCond, overTempCond, overTempAllCond,
                   supplyBelowLowWarning, supplyBelowUndervoltage,
                   supplyAboveOvervoltage, logicSupplyUndervoltage, ~clearFaultPin_n};

   always_comb begin
      syncA_next = rawIn;
      syncB_next = syncA_reg;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA_reg <= '0;
         syncB_reg <= '0;
      end else begin
         syncA_reg <= syncA_next;
         syncB_reg <= syncB_next;
      end
   end

   logic [NCH-1:0] olS;
   logic [NCH-1:0] ocS;
   logic [NCH-1:0] otS;
   logic           otAllS;
   logic           supLowS;
   logic           supUvS;
   logic           supOvS;
   logic           logicUvS;
   logic           clrPinS;
   assign {olS, ocS, otS, otAllS, supLowS, supUvS, supOvS, logicUvS, clrPinS} = syncB_reg;

   // link loss comes from the barrier logic on this clock
   logic           commS;
   assign commS = commLinkLost;

   // supply state decoded into the two status bits
   sdr_sup_t supState;
   always_comb begin
      if (supUvS) begin
         supState = SDR_SUP_UV;
      end else if (supOvS) begin
         supState = SDR_SUP_OV;
      end else if (supLowS) begin
         supState = SDR_SUP_LOW;
      end else begin
         supState = SDR_SUP_OK;
      end
   end

   // per-diagnostic live conditions, channel ones or-ed for the masks
   sdr_diag_t cond;
   always_comb begin
      cond                      = '0;
      cond[`SDR_BIT_OPEN_LOAD]  = |olS;
      cond[`SDR_BIT_OVER_CUR]   = |ocS;
      cond[`SDR_BIT_OT_CNS]     = |otS;
      cond[`SDR_BIT_OT_SD]      = otAllS;
      cond[`SDR_BIT_SUP_LOW]    = supState[0];
      cond[`SDR_BIT_SUP_OS]     = supState[1];
      cond[`SDR_BIT_LOGIC_UV]   = logicUvS;
      cond[`SDR_BIT_COMM_ERR]   = commS;
   end

   // clear strobe: command bits are pulses, pin clears everything
   sdr_diag_t clrPulse;
   always_comb begin
      clrPulse = '0;
      if (HAS_SERIAL && clearDiagnosticWrite) begin
         clrPulse = clearDiagnosticData;
      end
      if (!HAS_SERIAL && HAS_CLEAR_PIN && clrPinS) begin
         clrPulse = 8'hff;
      end
   end

   // masks
   sdr_diag_t fltEn_reg;
   sdr_diag_t fltEn_next;
   sdr_diag_t aclrEn_reg;
   sdr_diag_t aclrEn_next;
   sdr_diag_t aclrEff;
   always_comb begin
      fltEn_next  = fltEn_reg;
      aclrEn_next = aclrEn_reg;
      if (HAS_SERIAL && faultEnableWrite) begin
         fltEn_next = faultEnableData;
      end
      if (HAS_SERIAL && autoClearEnableWrite) begin
         aclrEn_next = autoClearEnableData;
      end
      aclrEn_next[`SDR_BIT_LOGIC_UV] = 1'b1;
      // parallel parts without a clear pin always auto clear
      aclrEff = (!HAS_SERIAL && !HAS_CLEAR_PIN) ? 8'hff : aclrEn_reg;
      if (!HAS_SERIAL && HAS_CLEAR_PIN) begin
         aclrEff = 8'h00;
         aclrEff[`SDR_BIT_LOGIC_UV] = 1'b1;
      end
   end

   // report latches: all-channel diagnostics and per-channel vectors
   sdr_diag_t      rep_reg;
   sdr_diag_t      rep_next;
   logic [NCH-1:0] olRep_reg;
   logic [NCH-1:0] ocRep_reg;
   logic [NCH-1:0] otRep_reg;
   logic [NCH-1:0] olRep_next;
   logic [NCH-1:0] ocRep_next;
   logic [NCH-1:0] otRep_next;

   // condition sets, set wins over clear; release needs clear or auto clear
   function automatic logic latchBit(input logic c, input logic r, input logic clr,
                                     input logic aclr);
      latchBit = c | (r & ~clr & ~aclr);
   endfunction

   always_comb begin
      for (int i = 0; i < `SDR_NUM_DIAG; i++) begin
         rep_next[i] = latchBit(cond[i], rep_reg[i], clrPulse[i], aclrEff[i]);
      end
      for (int c = 0; c < NCH; c++) begin
         olRep_next[c] = latchBit(olS[c], olRep_reg[c], clrPulse[`SDR_BIT_OPEN_LOAD],
                                  aclrEff[`SDR_BIT_OPEN_LOAD]);
         ocRep_next[c] = latchBit(ocS[c], ocRep_reg[c], clrPulse[`SDR_BIT_OVER_CUR],
                                  aclrEff[`SDR_BIT_OVER_CUR]);
         otRep_next[c] = latchBit(otS[c], otRep_reg[c], clrPulse[`SDR_BIT_OT_CNS],
                                  aclrEff[`SDR_BIT_OT_CNS]);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fltEn_reg  <= `SDR_FAULT_ENABLE_MASK_RESET;
         aclrEn_reg <= `SDR_AUTO_CLEAR_ENABLE_MASK_RESET;
         rep_reg    <= '0;
         olRep_reg  <= '0;
         ocRep_reg  <= '0;
         otRep_reg  <= '0;
      end else begin
         fltEn_reg  <= fltEn_next;
         aclrEn_reg <= aclrEn_next;
         rep_reg    <= rep_next;
         olRep_reg  <= olRep_next;
         ocRep_reg  <= ocRep_next;
         otRep_reg  <= otRep_next;
      end
   end

   // output gating follows live conditions; link loss cuts at once, then holds via its report
   logic           allOff;
   logic [NCH-1:0] chOn_next;
   logic [NCH-1:0] chOn_reg;
   logic           clampLow_next;
   logic           clampLow_reg;
   logic           flt_next;
   logic           flt_reg;
   logic           wrn_next;
   logic           wrn_reg;
   always_comb begin
      allOff = otAllS | supUvS | logicUvS | commS
               | rep_reg[`SDR_BIT_COMM_ERR];
      for (int c = 0; c < NCH; c++) begin
         // over-current turns off now; any hot channel blocks fresh turn-on of every channel
         chOn_next[c] = channelOnRequest[c] & ~allOff & ~ocS[c]
                        & (chOn_reg[c] | ~(|otS));
      end
      clampLow_next = supOvS | (|otS) | otAllS;
      flt_next      = |(rep_reg & fltEn_reg);
      wrn_next      = supLowS | supUvS;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chOn_reg     <= '0;
         clampLow_reg <= 1'b0;
         flt_reg      <= 1'b0;
         wrn_reg      <= 1'b0;
      end else begin
         chOn_reg     <= chOn_next;
         clampLow_reg <= clampLow_next;
         flt_reg      <= flt_next;
         wrn_reg      <= wrn_next;
      end
   end

   // open drain: output enable low while pulling the pin low
   assign faultIndicatorPinOut = 1'b0;
   assign faultIndicatorPinOe  = ~flt_reg;
   assign supplyWarningPinOut  = 1'b0;
   assign supplyWarningPinOe   = ~wrn_reg;
   assign channelEnable        = chOn_reg;
   assign clampLowVoltage      = clampLow_reg;
   assign faultEnableMask      = fltEn_reg;
   assign autoClearEnableMask  = aclrEn_reg;
   assign openLoadReport       = olRep_reg;
   assign overCurrentReport    = ocRep_reg;
   assign overTempReport       = otRep_reg;

   always_comb begin
      masterDiagnosticStatus                     = '0;
      masterDiagnosticStatus[`SDR_MST_OT_SD]     = rep_reg[`SDR_BIT_OT_SD];
      masterDiagnosticStatus[`SDR_MST_SUP_LOW]   = rep_reg[`SDR_BIT_SUP_LOW];
      masterDiagnosticStatus[`SDR_MST_SUP_OS]    = rep_reg[`SDR_BIT_SUP_OS];
      masterDiagnosticStatus[`SDR_MST_COMM_ERR]  = rep_reg[`SDR_BIT_COMM_ERR];
   end
endmodule // sdr_diag_report

// ===== include/sdr_regs.svh
// register layout and reset values of the switch diagnostic reporting block
`ifndef SDR_REGS_SVH
`define SDR_REGS_SVH
// diagnostic bit positions in the masks and the report vector
`define SDR_BIT_OPEN_LOAD  0
`define SDR_BIT_OVER_CUR   1
`define SDR_BIT_OT_CNS     2
`define SDR_BIT_OT_SD      3
`define SDR_BIT_SUP_LOW    4
`define SDR_BIT_SUP_OS     5
`define SDR_BIT_LOGIC_UV   6
`define SDR_BIT_COMM_ERR   7
// master diagnostic status layout
`define SDR_MST_OT_SD      3
`define SDR_MST_SUP_LOW    4
`define SDR_MST_SUP_OS     5
`define SDR_MST_COMM_ERR   7
// reset masks: faults only drive the indicator, everything auto clears
`define SDR_FAULT_ENABLE_MASK_RESET   8'hee
`define SDR_AUTO_CLEAR_ENABLE_MASK_RESET  8'hff
`define SDR_NUM_DIAG       8
`define SDR_NUM_CH         2
`endif

// ===== include/sdr_pkg.sv
// types of the switch diagnostic reporting block
package sdr_pkg;
   typedef logic [7:0] sdr_diag_t;
   typedef enum logic [1:0] {
      SDR_SUP_OK  = 2'b00,
      SDR_SUP_LOW = 2'b01,
      SDR_SUP_OV  = 2'b10,
      SDR_SUP_UV  = 2'b11
   } sdr_sup_t;
endpackage

// ===== bench/sdr_host_model.sv
// host side pin model: pull-ups on the open-drain indicator lines
`timescale 1ns/1ps
module sdr_host_model (
   input  wire logic fltOut,
   input  wire logic fltOe,
   input  wire logic wrnOut,
   input  wire logic wrnOe,
   output logic      faultPin,
   output logic      warnPin
);
   assign faultPin = fltOe ? 1'b1 : fltOut;
   assign warnPin  = wrnOe ? 1'b1 : wrnOut;
endmodule // sdr_host_model

// ===== bench/sdr_diag_report_sva.sv
// assertions on the ports of the diagnostic reporting block
`timescale 1ns/1ps
module sdr_diag_report_sva (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       commLinkLost,
   input wire logic       faultEnableWrite,
   input wire logic [7:0] faultEnableData,
   input wire logic       clearDiagnosticWrite,
   input wire logic [7:0] faultEnableMask,
   input wire logic [7:0] autoClearEnableMask,
   input wire logic [7:0] masterDiagnosticStatus,
   input wire logic [1:0] overCurrentReport,
   input wire logic       faultIndicatorPinOe,
   input wire logic       supplyWarningPinOe,
   input wire logic [1:0] channelEnable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_oc_fault_pin: assert property ((|overCurrentReport) && faultEnableMask[1]
      |=> !faultIndicatorPinOe) else $error("fault pin not low");
   a_oc_chan_off: assert property ($rose(overCurrentReport[0])
      |-> !channelEnable[0]) else $error("channel on with overcurrent");
   a_comm_report: assert property (commLinkLost
      |=> masterDiagnosticStatus[7]) else $error("comm error not reported");
   a_comm_outputs_off: assert property (masterDiagnosticStatus[7]
      |-> channelEnable == 2'h0) else $error("outputs on with comm error");
   a_reserved_zero: assert property (masterDiagnosticStatus[2:0] == 3'h0
      && !masterDiagnosticStatus[6]) else $error("reserved status bit set");
   a_aclr_fixed: assert property (autoClearEnableMask[6])
      else $error("logic supply auto clear off");
   a_latched_hold: assert property (overCurrentReport[0] && !autoClearEnableMask[1]
      && !clearDiagnosticWrite |=> overCurrentReport[0]) else $error("latched report lost");
   a_mask_write: assert property (faultEnableWrite
      |=> faultEnableMask == $past(faultEnableData)) else $error("fault mask not written");
   a_warn_pin: assert property (masterDiagnosticStatus[4] && autoClearEnableMask[4]
      |-> ##[0:1] !supplyWarningPinOe) else $error("warning pin not low");
endmodule // sdr_diag_report_sva
bind sdr_diag_report sdr_diag_report_sva u_sva (.clk(clk), .rst_n(rst_n),
   .commLinkLost(commLinkLost), .faultEnableWrite(faultEnableWrite),
   .faultEnableData(faultEnableData), .clearDiagnosticWrite(clearDiagnosticWrite),
   .faultEnableMask(faultEnableMask), .autoClearEnableMask(autoClearEnableMask),
   .masterDiagnosticStatus(masterDiagnosticStatus), .overCurrentReport(overCurrentReport),
   .faultIndicatorPinOe(faultIndicatorPinOe), .supplyWarningPinOe(supplyWarningPinOe),
   .channelEnable(channelEnable));

// ===== bench/tb_top.sv
// self-checking bench of the diagnostic reporting block
`timescale 1ns/1ps
module tb_top;
   logic       clk = 1'b0, rst_n = 1'b0, feW = 1'b0, acW = 1'b0, clW = 1'b0;
   logic       otAll = 1'b0, supLow = 1'b0, supUv = 1'b0, supOv = 1'b0;
   logic       logicUv = 1'b0, linkLost = 1'b0;
   logic [1:0] olCond = 2'h0, ocCond = 2'h0, otCond = 2'h0, chReq = 2'h3;
   logic [7:0] wData = 8'h00;
   logic [4:0] v;
   logic [31:0] lfsr = 32'h490e;
   logic [7:0] feMask, acMask, mst;
   logic [1:0] olRep, ocRep, otRep, chEn;
   logic       fltOut, fltOe, wrnOut, wrnOe, clampLow, fltPin, wrnPin;
   int         n_errors = 0;
   int         cmp_count = 0;
   always #4 clk = ~clk;
   sdr_diag_report u_sdr_diag_report (.clk(clk), .rst_n(rst_n), .openLoadCond(olCond),
      .overCurrentCond(ocCond), .overTempCond(otCond), .overTempAllCond(otAll),
      .supplyBelowLowWarning(supLow), .supplyBelowUndervoltage(supUv),
      .supplyAboveOvervoltage(supOv), .logicSupplyUndervoltage(logicUv),
      .commLinkLost(linkLost), .channelOnRequest(chReq), .clearFaultPin_n(1'b1),
      .faultEnableWrite(feW), .faultEnableData(wData), .autoClearEnableWrite(acW),
      .autoClearEnableData(wData), .clearDiagnosticWrite(clW), .clearDiagnosticData(wData),
      .faultEnableMask(feMask), .autoClearEnableMask(acMask), .masterDiagnosticStatus(mst),
      .openLoadReport(olRep), .overCurrentReport(ocRep), .overTempReport(otRep),
      .faultIndicatorPinOut(fltOut), .faultIndicatorPinOe(fltOe),
      .supplyWarningPinOut(wrnOut), .supplyWarningPinOe(wrnOe), .channelEnable(chEn),
      .clampLowVoltage(clampLow));
   sdr_host_model u_sdr_host_model (.fltOut(fltOut), .fltOe(fltOe), .wrnOut(wrnOut),
      .wrnOe(wrnOe), .faultPin(fltPin), .warnPin(wrnPin));
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input int sel, input logic [7:0] d);
      wData = d;
      {clW, acW, feW} = 3'h1 << sel;
      @(negedge clk);
      {clW, acW, feW} = 3'h0;
      @(negedge clk);
   endtask
   task automatic st();
      repeat (6) @(negedge clk);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      print_verdict();
   end
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      st();
      chk(feMask, 8'hee);
      chk(acMask, 8'hff);
      chk({7'h0, fltPin}, 8'h1);
      $display("reset test done");
      for (int i = 0; i < 5; i++) begin
         v = 5'h1 << i;
         {logicUv, otAll, supOv, supUv, supLow} = v;
         st();
         chk(mst, {2'h0, v[2] | v[1], v[0] | v[1], v[3], 3'h0});
         chk({6'h0, chEn}, (v[1] | v[3] | v[4]) ? 8'h0 : 8'h3);
         chk({7'h0, fltPin}, {7'h0, ~|v[4:1]});
         chk({7'h0, wrnPin}, {7'h0, ~(v[0] | v[1])});
         chk({7'h0, clampLow}, {7'h0, v[2] | v[3]});
         {logicUv, otAll, supOv, supUv, supLow} = 5'h0;
         st();
         chk(mst, 8'h00);
      end
      $display("supply test done");
      otCond = 2'h1;
      st();
      chk({4'h0, otRep, chEn}, 8'h7);
      chk({7'h0, clampLow}, 8'h1);
      chk({7'h0, fltPin}, 8'h0);
      chReq = 2'h0;
      @(negedge clk);
      chReq = 2'h3;
      st();
      chk({6'h0, chEn}, 8'h0);
      otCond = 2'h0;
      st();
      chk({4'h0, otRep, chEn}, 8'h3);
      $display("temperature test done");
      ocCond = 2'h1;
      st();
      chk({6'h0, ocRep, chEn}, 8'h6);
      chk({7'h0, fltPin}, 8'h0);
      ocCond = 2'h0;
      st();
      chk({6'h0, ocRep, chEn}, 8'h3);
      wr(0, 8'h00);
      chk(feMask, 8'h00);
      ocCond = 2'h1;
      st();
      chk({7'h0, fltPin}, 8'h1);
      ocCond = 2'h0;
      wr(0, 8'hee);
      wr(1, 8'hbd);
      chk(acMask, 8'hfd);
      ocCond = 2'h1;
      st();
      wData = 8'h02;
      clW   = 1'b1;
      @(negedge clk);
      clW = 1'b0;
      chk({6'h0, ocRep}, 8'h1);
      st();
      chk({6'h0, ocRep}, 8'h1);
      ocCond = 2'h0;
      st();
      chk({6'h0, ocRep, chEn}, 8'h7);
      wr(2, 8'h02);
      st();
      chk({6'h0, ocRep}, 8'h0);
      ocCond = 2'h1;
      st();
      ocCond = 2'h0;
      st();
      chk({6'h0, ocRep}, 8'h1);
      wr(2, 8'h02);
      wr(1, 8'hff);
      $display("latch test done");
      linkLost = 1'b1;
      repeat (3) @(negedge clk);
      chk({mst[7], 5'h0, chEn}, 8'h80);
      linkLost = 1'b0;
      st();
      chk({mst[7], 5'h0, chEn}, 8'h03);
      $display("link test done");
      for (int i = 0; i < 20; i++) begin
         lfsr = nextRand(lfsr);
         olCond = lfsr[1:0];
         chReq = lfsr[3:2];
         st();
         chk({olRep, 3'h0, fltPin, chEn}, {lfsr[1:0], 4'h1, lfsr[3:2]});
      end
      $display("random test done");
      print_verdict();
   end
endmodule // tb_top
